// ---- core/clear_and_invert_ops_pkg.sv ----
// Constants and types shared by the clear and invert instruction block
package clear_and_invert_ops_pkg;
  localparam int          INSTR_W        = 12;
  localparam int          PC_W           = 11;
  localparam int          DATA_W         = 8;
  localparam int          FADDR_W        = 5;
  localparam logic [11:0] OP_KICK_GUARD  = 12'h004;
  localparam logic [11:0] CALL_MASK      = 12'hf00;
  localparam logic [11:0] CALL_CODE      = 12'h900;
  localparam logic [11:0] WIPE_MASK      = 12'hfe0;
  localparam logic [11:0] WIPE_CODE      = 12'h060;
  localparam logic [11:0] INVERT_MASK    = 12'hfc0;
  localparam logic [11:0] INVERT_CODE    = 12'h240;
  localparam int          DEST_BIT       = 5;
  localparam logic [7:0]  ZERO_BYTE      = 8'h00;
  localparam logic [10:0] PC_RESET       = 11'h7ff;
  localparam logic [10:0] PC_STEP        = 11'h001;
  localparam logic [7:0]  COUNT_STEP     = 8'h01;
  localparam logic [7:0]  COUNT_TOP      = 8'hff;

  typedef enum logic {PH_EXEC, PH_FLUSH} phase_t;

  typedef struct packed {
    phase_t      phase;
    logic [10:0] pc;
    logic [10:0] stack_head;
    logic [10:0] stack_low;
    logic [7:0]  w;
    logic        null_result_flag;
    logic        expired_guard_flag;
    logic        sleep_entered_flag;
    logic [7:0]  guard_timer;
    logic [7:0]  prescaler;
    logic        file_we;
    logic [4:0]  file_wr_addr;
    logic [7:0]  file_wr_data;
  } state_t;
endpackage

// ---- core/clear_and_invert_ops.sv ----
// Execution core for call, wipe, guard kick and invert instructions
`timescale 1ns/1ns
`default_nettype none

// How it works
// - After call: PC=target, stack head=call+1
// - Wipe writes 00h, sets null flag only
// - Kick zeroes guard timer, prescaler if assigned
// - Kick sets expired and sleep flags only
// - Opcode 0000 0000 0100 is kick
// - Invert complements file to W or file
// - Call pushes PC+1 in the same cycle as loading target
// - Call takes two cycles, second is idle
module clear_and_invert_ops (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic [11:0] instr,
  input  wire logic [7:0]  file_rd_data,
  input  wire logic [1:0]  page_select,
  input  wire logic        prescaler_to_guard,
  input  wire logic        guard_tick,
  output logic      [10:0] pc,
  output logic      [10:0] stack_head,
  output logic      [7:0]  w,
  output logic             null_result_flag,
  output logic             expired_guard_flag,
  output logic             sleep_entered_flag,
  output logic      [7:0]  guard_timer,
  output logic      [7:0]  prescaler,
  output logic             file_we,
  output logic      [4:0]  file_wr_addr,
  output logic      [7:0]  file_wr_data,
  output logic             flushing
);
  // Short local names for the shared constants
  localparam int          DATA_W      = clear_and_invert_ops_pkg::DATA_W;
  localparam int          FADDR_W     = clear_and_invert_ops_pkg::FADDR_W;
  localparam int          PC_W        = clear_and_invert_ops_pkg::PC_W;
  localparam int          DEST_BIT    = clear_and_invert_ops_pkg::DEST_BIT;
  localparam logic [11:0] KICK_OP     = clear_and_invert_ops_pkg::OP_KICK_GUARD;
  localparam logic [11:0] CALL_MASK   = clear_and_invert_ops_pkg::CALL_MASK;
  localparam logic [11:0] CALL_CODE   = clear_and_invert_ops_pkg::CALL_CODE;
  localparam logic [11:0] WIPE_MASK   = clear_and_invert_ops_pkg::WIPE_MASK;
  localparam logic [11:0] WIPE_CODE   = clear_and_invert_ops_pkg::WIPE_CODE;
  localparam logic [11:0] INVERT_MASK = clear_and_invert_ops_pkg::INVERT_MASK;
  localparam logic [11:0] INVERT_CODE = clear_and_invert_ops_pkg::INVERT_CODE;
  localparam logic [7:0]  ZERO_BYTE   = clear_and_invert_ops_pkg::ZERO_BYTE;
  localparam logic [7:0]  COUNT_STEP  = clear_and_invert_ops_pkg::COUNT_STEP;
  localparam logic [7:0]  COUNT_TOP   = clear_and_invert_ops_pkg::COUNT_TOP;
  localparam logic [10:0] PC_RESET    = clear_and_invert_ops_pkg::PC_RESET;
  localparam logic [10:0] PC_STEP     = clear_and_invert_ops_pkg::PC_STEP;

  // Call literal fills the low byte; the page sits above one cleared bit
  localparam int          LIT_W       = DATA_W;
  localparam int          PAGE_W      = PC_W - DATA_W - 1;

  // Status flags of the guard start high, as after power-up
  localparam clear_and_invert_ops_pkg::state_t RESET_STATE = '{
    phase:              clear_and_invert_ops_pkg::PH_EXEC,
    pc:                 PC_RESET,
    stack_head:         '0,
    stack_low:          '0,
    w:                  ZERO_BYTE,
    null_result_flag:   1'h0,
    expired_guard_flag: 1'h1,
    sleep_entered_flag: 1'h1,
    guard_timer:        ZERO_BYTE,
    prescaler:          ZERO_BYTE,
    file_we:            1'h0,
    file_wr_addr:       '0,
    file_wr_data:       ZERO_BYTE
  };

  clear_and_invert_ops_pkg::state_t state_reg;
  clear_and_invert_ops_pkg::state_t state_next;

  logic                 is_kick;
  logic                 is_call;
  logic                 is_wipe;
  logic                 is_invert;
  logic                 dest_is_file;
  logic [FADDR_W-1:0]   file_addr;
  logic [LIT_W-1:0]     call_literal;
  logic [PAGE_W-1:0]    page_bits;
  logic [DATA_W-1:0]    inverted;
  logic                 inverted_is_zero;
  logic [10:0]          pc_plus_one;
  logic [10:0]          call_target;
  logic                 prescaler_wrap;
  logic                 guard_step;
  logic                 guard_wrap;

  // Instruction decode
  // Kick opcode match
  assign is_kick          = (instr == KICK_OP);
  assign is_call          = ((instr & CALL_MASK) == CALL_CODE);
  assign is_wipe          = ((instr & WIPE_MASK) == WIPE_CODE);
  assign is_invert        = ((instr & INVERT_MASK) == INVERT_CODE);
  assign dest_is_file     = instr[DEST_BIT];
  assign file_addr        = instr[FADDR_W-1:0];
  assign call_literal     = instr[LIT_W-1:0];
  assign page_bits        = page_select;

  genvar bit_idx;
  generate
    for (bit_idx = 0; bit_idx < DATA_W; bit_idx = bit_idx + 1) begin : g_invert
      assign inverted[bit_idx] = ~file_rd_data[bit_idx];
    end
  endgenerate

  assign inverted_is_zero = (inverted == ZERO_BYTE);

  // Return address is the next word
  assign pc_plus_one      = state_reg.pc + PC_STEP;

  assign call_target      = {page_bits, 1'h0, call_literal};

  // The prescaler counts every tick; the guard uses its wrap only when assigned
  assign prescaler_wrap   = guard_tick && (state_reg.prescaler == COUNT_TOP);
  assign guard_step       = prescaler_to_guard ? prescaler_wrap : guard_tick;
  assign guard_wrap       = guard_step && (state_reg.guard_timer == COUNT_TOP);

  always_comb begin
    state_next         = state_reg;
    state_next.file_we = 1'h0;

    // Free-running counting; a kick below overrides the guard timer, and the prescaler when assigned, in the same cycle
    if (guard_tick) begin
      state_next.prescaler = state_reg.prescaler + COUNT_STEP;
    end
    if (guard_step) begin
      state_next.guard_timer = state_reg.guard_timer + COUNT_STEP;
    end
    // A guard overflow drops the expired flag until the next kick
    if (guard_wrap) begin
      state_next.expired_guard_flag = 1'h0;
    end

    case (state_reg.phase)
      clear_and_invert_ops_pkg::PH_FLUSH: begin
        state_next.phase = clear_and_invert_ops_pkg::PH_EXEC;
      end

      clear_and_invert_ops_pkg::PH_EXEC: begin
        // Single-cycle ops advance by one word
        state_next.pc = pc_plus_one;

        if (is_call) begin
          state_next.stack_low  = state_reg.stack_head;
          state_next.stack_head = pc_plus_one;
          state_next.pc         = call_target;
          state_next.phase      = clear_and_invert_ops_pkg::PH_FLUSH;
        end else if (is_kick) begin
          state_next.guard_timer = ZERO_BYTE;
          if (prescaler_to_guard) begin
            state_next.prescaler = ZERO_BYTE;
          end
          state_next.expired_guard_flag = 1'h1;
          state_next.sleep_entered_flag = 1'h1;
        end else if (is_wipe) begin
          state_next.file_we          = 1'h1;
          state_next.file_wr_addr     = file_addr;
          state_next.file_wr_data     = ZERO_BYTE;
          state_next.null_result_flag = 1'h1;
        end else if (is_invert) begin
          if (dest_is_file) begin
            state_next.file_we      = 1'h1;
            state_next.file_wr_addr = file_addr;
            state_next.file_wr_data = inverted;
          end else begin
            state_next.w = inverted;
          end
          state_next.null_result_flag = inverted_is_zero;
        end else begin
          // Other opcodes belong to other blocks; here only the PC moves on by one word
          state_next.phase = clear_and_invert_ops_pkg::PH_EXEC;
        end
      end

      default: begin
        state_next.phase = clear_and_invert_ops_pkg::PH_EXEC;
      end
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= RESET_STATE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Every output is a field of the state register
  assign pc                 = state_reg.pc;
  assign stack_head         = state_reg.stack_head;
  assign w                  = state_reg.w;
  assign null_result_flag   = state_reg.null_result_flag;
  assign expired_guard_flag = state_reg.expired_guard_flag;
  assign sleep_entered_flag = state_reg.sleep_entered_flag;
  assign guard_timer        = state_reg.guard_timer;
  assign prescaler          = state_reg.prescaler;
  assign file_we            = state_reg.file_we;
  assign file_wr_addr       = state_reg.file_wr_addr;
  assign file_wr_data       = state_reg.file_wr_data;
  // The lower stack level is kept in the state register only; no output carries it
  assign flushing           = (state_reg.phase == clear_and_invert_ops_pkg::PH_FLUSH);
endmodule
`default_nettype wire

// ---- sim/clear_and_invert_ops_assertions.sv ----
// Checker for the clear and invert block
`timescale 1ns/1ns
`default_nettype none
module clear_and_invert_ops_assertions (
  input wire logic        clk,
  input wire logic        resetn,
  input wire logic [11:0] instr,
  input wire logic [7:0]  file_rd_data,
  input wire logic [1:0]  page_select,
  input wire logic [10:0] pc,
  input wire logic [10:0] stack_head,
  input wire logic        null_result_flag,
  input wire logic        expired_guard_flag,
  input wire logic        sleep_entered_flag,
  input wire logic [7:0]  guard_timer,
  input wire logic        file_we,
  input wire logic [7:0]  file_wr_data,
  input wire logic        flushing
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);

  logic is_kick;
  logic is_call;
  logic is_wipe;
  logic is_invert;
  assign is_kick   = (instr == clear_and_invert_ops_pkg::OP_KICK_GUARD) && !flushing;
  assign is_call   = ((instr & clear_and_invert_ops_pkg::CALL_MASK)
                     == clear_and_invert_ops_pkg::CALL_CODE) && !flushing;
  assign is_wipe   = ((instr & clear_and_invert_ops_pkg::WIPE_MASK)
                     == clear_and_invert_ops_pkg::WIPE_CODE) && !flushing;
  assign is_invert = ((instr & clear_and_invert_ops_pkg::INVERT_MASK)
                     == clear_and_invert_ops_pkg::INVERT_CODE) && !flushing;

  sequence s_call_issued;
    is_call;
  endsequence

  sequence s_call_done;
    flushing ##1 !flushing;
  endsequence

  a_kick_zero: assert property (is_kick |=> guard_timer == 8'h00)
    else $error("guard timer not cleared by kick");
  a_kick_flags: assert property (is_kick |=> expired_guard_flag && sleep_entered_flag)
    else $error("guard flags not set by kick");
  a_call_flush: assert property (s_call_issued |=> s_call_done)
    else $error("call did not spend exactly one flush cycle");
  a_call_target: assert property (s_call_issued |=>
    pc == {$past(page_select), 1'h0, $past(instr[7:0])})
    else $error("call target not loaded");
  a_call_push: assert property (s_call_issued |=> stack_head == $past(pc) + 11'h001)
    else $error("return address not pushed");
  a_wipe_write: assert property (is_wipe |=>
    file_we && file_wr_data == 8'h00 && null_result_flag)
    else $error("wipe did not write zero");
  a_invert_file: assert property (is_invert && instr[5] |=>
    file_we && file_wr_data == ~$past(file_rd_data))
    else $error("invert did not write complement");
endmodule
`default_nettype wire

// ---- sim/test_clear_and_invert_ops.sv ----
// Bench for the clear and invert block
`timescale 1ns/1ns
`default_nettype none
module test_clear_and_invert_ops;
  logic        clk = 1'h0;
  logic        resetn = 1'h0;
  logic [11:0] instr = 12'h000;
  logic [7:0]  file_rd_data = 8'h00;
  logic [1:0]  page_select = 2'h0;
  logic        prescaler_to_guard = 1'h0;
  logic        guard_tick = 1'h0;
  logic [10:0] pc;
  logic [10:0] stack_head;
  logic [7:0]  w;
  logic        null_result_flag;
  logic        expired_guard_flag;
  logic        sleep_entered_flag;
  logic [7:0]  guard_timer;
  logic [7:0]  prescaler;
  logic        file_we;
  logic [4:0]  file_wr_addr;
  logic [7:0]  file_wr_data;
  logic        flushing;
  int          bad_count = 0;
  int          compares = 0;

  always #5 clk = ~clk;

  clear_and_invert_ops clear_and_invert_ops_i (
    .clk                (clk),
    .resetn             (resetn),
    .instr              (instr),
    .file_rd_data       (file_rd_data),
    .page_select        (page_select),
    .prescaler_to_guard (prescaler_to_guard),
    .guard_tick         (guard_tick),
    .pc                 (pc),
    .stack_head         (stack_head),
    .w                  (w),
    .null_result_flag   (null_result_flag),
    .expired_guard_flag (expired_guard_flag),
    .sleep_entered_flag (sleep_entered_flag),
    .guard_timer        (guard_timer),
    .prescaler          (prescaler),
    .file_we            (file_we),
    .file_wr_addr       (file_wr_addr),
    .file_wr_data       (file_wr_data),
    .flushing           (flushing)
  );

  task automatic print_verdict();
    $display("mismatches %0d, comparisons %0d", bad_count, compares);
    if (bad_count == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic check(input logic [15:0] got, input logic [15:0] expected);
    compares++;
    if (got !== expected) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, expected);
    end
  endtask

  // Drives one opcode for one cycle, then a no-op; outputs are settled on return
  task automatic run_op(input logic [11:0] op);
    instr = op;
    @(negedge clk);
    instr = 12'h000;
  endtask

  task automatic reset_scenario();
    resetn = 1'h0;
    #1;
    check(pc, 16'h07ff);
    check({expired_guard_flag, sleep_entered_flag, flushing, file_we}, 16'hc);
    @(negedge clk);
    @(negedge clk);
    resetn = 1'h1;
    @(negedge clk);
    check(pc, 16'h0000);
  endtask

  task automatic invert_scenario();
    file_rd_data = 8'h13;
    run_op(12'h247);
    check({file_we, null_result_flag, w}, {8'h00, 8'hec});
    file_rd_data = 8'hff;
    run_op(12'h263);
    check({file_we, null_result_flag, file_wr_data}, {8'h03, 8'h00});
    check({file_wr_addr, w}, {3'h0, 5'h03, 8'hec});
    @(negedge clk);
    check(file_we, 16'h0000);
  endtask

  task automatic wipe_scenario();
    logic [10:0] start_pc;
    file_rd_data = 8'h13;
    run_op(12'h247);
    check(null_result_flag, 16'h0000);
    start_pc = pc;
    run_op(12'h06a);
    check({file_we, null_result_flag, file_wr_data}, {8'h03, 8'h00});
    check({file_wr_addr, w}, {3'h0, 5'h0a, 8'hec});
    check(pc, start_pc + 11'h001);
  endtask

  task automatic kick_scenario();
    logic [7:0]  held_prescaler;
    logic [10:0] start_pc;
    prescaler_to_guard = 1'h0;
    guard_tick = 1'h1;
    repeat (300) @(negedge clk);
    guard_tick = 1'h0;
    @(negedge clk);
    check(expired_guard_flag, 16'h0000);
    held_prescaler = prescaler;
    start_pc = pc;
    check(guard_timer == 8'h00, 16'h0000);
    run_op(12'h004);
    check({guard_timer, prescaler}, {8'h00, held_prescaler});
    check({expired_guard_flag, sleep_entered_flag}, 16'h0003);
    check(pc, start_pc + 11'h001);
    prescaler_to_guard = 1'h1;
    guard_tick = 1'h1;
    repeat (3) @(negedge clk);
    guard_tick = 1'h0;
    check(prescaler == 8'h00, 16'h0000);
    run_op(12'h004);
    check({guard_timer, prescaler}, 16'h0000);
  endtask

  task automatic call_scenario();
    logic [10:0] start_pc;
    page_select = 2'h2;
    start_pc = pc;
    instr = 12'h9a5;
    @(negedge clk);
    check(pc, 16'h04a5);
    check(stack_head, start_pc + 11'h001);
    check(flushing, 16'h0001);
    // A wipe offered in the flush cycle must be ignored
    instr = 12'h061;
    @(negedge clk);
    instr = 12'h000;
    check({flushing, file_we}, 16'h0000);
    check(pc, 16'h04a5);
    @(negedge clk);
    check(pc, 16'h04a6);
  endtask

  initial begin
    repeat (2) @(negedge clk);
    resetn = 1'h1;
    @(negedge clk);
    invert_scenario();
    wipe_scenario();
    kick_scenario();
    call_scenario();
    reset_scenario();
    call_scenario();
    print_verdict();
  end

  // Tests take about 320 cycles; allow ample margin
  initial begin
    repeat (5000) @(posedge clk);
    bad_count++;
    print_verdict();
  end
endmodule
bind clear_and_invert_ops clear_and_invert_ops_assertions chk_i (
  .clk                (clk),
  .resetn             (resetn),
  .instr              (instr),
  .file_rd_data       (file_rd_data),
  .page_select        (page_select),
  .pc                 (pc),
  .stack_head         (stack_head),
  .null_result_flag   (null_result_flag),
  .expired_guard_flag (expired_guard_flag),
  .sleep_entered_flag (sleep_entered_flag),
  .guard_timer        (guard_timer),
  .file_we            (file_we),
  .file_wr_data       (file_wr_data),
  .flushing           (flushing)
);
`default_nettype wire
